// ---- smpp_pkg.sv ----
// Shared constants, carriers and states of the serial programming host
package smpp_pkg;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned SCK_PHASE_NS = 1000;
  localparam int unsigned SCK_PHASE_CYC = (SCK_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TGT_CLK_HALF_NS = 64;
  localparam int unsigned TGT_CLK_HALF_CYC = TGT_CLK_HALF_NS / CLK_PERIOD_NS;
  localparam int unsigned RST_PULSE_NS = 2000;
  localparam int unsigned RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POWER_UP_WAIT_NS = 20_000_000;
  localparam int unsigned POWER_UP_WAIT_CYC =
    (POWER_UP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROGRAM_PAGE_WAIT_DELAY_NS = 4_500_000;
  localparam int unsigned PROGRAM_PAGE_WAIT_DELAY_CYC =
    (PROGRAM_PAGE_WAIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EEPROM_BYTE_WAIT_DELAY_NS = 9_000_000;
  localparam int unsigned EEPROM_BYTE_WAIT_DELAY_CYC =
    (EEPROM_BYTE_WAIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ERASE_WAIT_NS = 9_000_000;
  localparam int unsigned ERASE_WAIT_CYC = (ERASE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FUSE_WAIT_NS = 4_500_000;
  localparam int unsigned FUSE_WAIT_CYC = (FUSE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // --------------------------------------------------------------------------
  // Instruction encodings
  // --------------------------------------------------------------------------
  localparam logic [7:0] OP_PROG_ENABLE = 8'hac;
  localparam logic [7:0] ENABLE_ECHO = 8'h53;
  localparam logic [2:0] ERASE_SEL = 3'h4;
  localparam logic [2:0] FUSE_LOCK_SEL_MASK = 3'h5;
  localparam logic [2:0] FUSE_LOCK_SEL = 3'h5;
  localparam logic [7:0] OP_LOAD_PAGE = 8'h40;
  localparam logic [7:0] OP_LOAD_MASK = 8'hf7;
  localparam int unsigned LOAD_HIGH_BIT = 3;
  localparam logic [7:0] LOAD_ADDR_MASK = 8'h1f;
  localparam logic [7:0] OP_WRITE_PAGE = 8'h4c;
  localparam logic [7:0] OP_WRITE_EEPROM = 8'hc0;

  // --------------------------------------------------------------------------
  // Carriers and states
  // --------------------------------------------------------------------------
  localparam int unsigned INSTR_BITS = 32;
  localparam int unsigned FIFO_DEPTH = 16;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] addr_hi;
    logic [7:0] addr_lo;
    logic [7:0] data;
  } smpp_instr_s;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] data;
  } smpp_rsp_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RST_PULSE,
    ST_PWR_WAIT,
    ST_SHIFT,
    ST_WAIT,
    ST_READY
  } smpp_state_e;

endpackage : smpp_pkg

// ---- smpp_host.sv ----
// Serial programming host: instruction FIFO and target link sequencer
module smpp_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic push;
  logic pop;

  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr_reg];

  always_comb
  begin
    count_next = count_reg;
    if (push && !pop)
      count_next = count_reg + (AW + 1)'(1);
    else if (pop && !push)
      count_next = count_reg - (AW + 1)'(1);
  end

  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data_i;
  end

  // Flags registered from the next count so both sides see flop outputs
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      count_reg <= count_next;
      in_ready_o <= count_next != (AW + 1)'(DEPTH);
      out_valid_o <= count_next != '0;
    end
  end
endmodule : smpp_fifo

// Overview of operation
// - Program only while target reset held low
// - Keep a valid target clock whole session
// - Hold each SCK phase above limit
// - Power-up: reset, SCK low, then reset pulse
// - Wait 20 ms before enable instruction
// - Send all four bytes; bad echo retries
// - Page load: five address bits, low first
// - Wait flash delay after page write
// - One EEPROM byte per instruction, then wait
// - Releasing reset ends programming session
// - Enable is AC 53 plus two bytes
// - Erase is AC then 100 top bits
// - Write page opcode 4C with address
module smpp_host #(
  parameter int unsigned POWER_UP_WAIT = smpp_pkg::POWER_UP_WAIT_CYC,
  parameter int unsigned PAGE_WAIT = smpp_pkg::PROGRAM_PAGE_WAIT_DELAY_CYC,
  parameter int unsigned EEPROM_WAIT = smpp_pkg::EEPROM_BYTE_WAIT_DELAY_CYC,
  parameter int unsigned ERASE_WAIT = smpp_pkg::ERASE_WAIT_CYC,
  parameter int unsigned FUSE_WAIT = smpp_pkg::FUSE_WAIT_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic end_i,
  input wire logic cmd_valid_i,
  input wire smpp_pkg::smpp_instr_s cmd_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output smpp_pkg::smpp_rsp_s rsp_o,
  output logic active_o,
  output logic enabled_o,
  output logic sync_fail_o,
  output logic order_err_o,
  output logic tgt_rst_n_o,
  output logic tgt_clk_o,
  output logic sck_o,
  output logic mosi_o,
  input wire logic miso_i
);
  import smpp_pkg::*;

  // --------------------------------------------------------------------------
  // Decoding
  // --------------------------------------------------------------------------
  function automatic logic is_load(input logic [7:0] op);
    is_load = (op & OP_LOAD_MASK) == OP_LOAD_PAGE;
  endfunction : is_load

  function automatic logic [31:0] wait_of(input logic [7:0] op, input logic [7:0] sel);
    wait_of = 32'(SCK_PHASE_CYC);
    if (op == OP_WRITE_PAGE)
      wait_of = 32'(PAGE_WAIT);
    else if (op == OP_WRITE_EEPROM)
      wait_of = 32'(EEPROM_WAIT);
    else if (op == OP_PROG_ENABLE && sel[7:5] == ERASE_SEL)
      wait_of = 32'(ERASE_WAIT);
    else if (op == OP_PROG_ENABLE && (sel[7:5] & FUSE_LOCK_SEL_MASK) == FUSE_LOCK_SEL)
      wait_of = 32'(FUSE_WAIT);
  endfunction : wait_of

  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  smpp_state_e state_reg;
  logic [31:0] timer_reg;
  logic [15:0] ph_cnt_reg;
  logic [4:0] bit_cnt_reg;
  logic [31:0] tx_reg;
  logic [31:0] rx_reg;
  logic [7:0] op_reg;
  logic [7:0] sel_reg;
  logic [1:0] miso_sync_reg;
  logic [3:0] tclk_cnt_reg;
  logic enabling_reg;
  logic end_req_reg;
  logic [7:0] lo_addr_reg;
  logic lo_valid_reg;
  logic f_valid;
  smpp_instr_s f_data;
  logic take;
  logic ph_done;
  logic xfer_done;
  logic echo_ok;

  smpp_fifo #(
    .WIDTH(INSTR_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(cmd_valid_i),
    .in_data_i(cmd_i),
    .in_ready_o(cmd_ready_o),
    .out_valid_o(f_valid),
    .out_data_o(f_data),
    .out_ready_i(take)
  );

  assign take = state_reg == ST_READY && f_valid && !end_req_reg && !end_i;
  assign ph_done = ph_cnt_reg == 16'(SCK_PHASE_CYC - 1);
  assign xfer_done = state_reg == ST_SHIFT && sck_o && ph_done && bit_cnt_reg == 5'h1f;
  assign echo_ok = rx_reg[15:8] == ENABLE_ECHO;
  assign mosi_o = tx_reg[31];

  // --------------------------------------------------------------------------
  // Target clock and MISO synchroniser
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tclk_cnt_reg <= '0;
      tgt_clk_o <= 1'b0;
    end
    else if (tclk_cnt_reg == 4'(TGT_CLK_HALF_CYC - 1))
    begin
      tclk_cnt_reg <= '0;
      tgt_clk_o <= !tgt_clk_o;
    end
    else
      tclk_cnt_reg <= tclk_cnt_reg + 4'h1;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      miso_sync_reg <= '0;
    else
      miso_sync_reg <= {miso_sync_reg[0], miso_i};
  end

  // --------------------------------------------------------------------------
  // Session sequencer
  // --------------------------------------------------------------------------
  // Target stays in reset after host reset so SCK low is guaranteed early
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_IDLE;
      timer_reg <= '0;
      tgt_rst_n_o <= 1'b0;
      enabling_reg <= 1'b0;
      end_req_reg <= 1'b0;
    end
    else
    begin
      if (end_i && state_reg != ST_IDLE)
        end_req_reg <= 1'b1;
      unique case (state_reg)
        ST_IDLE:
          if (start_i)
          begin
            state_reg <= ST_RST_PULSE;
            timer_reg <= 32'(RST_PULSE_CYC - 1);
            tgt_rst_n_o <= 1'b1;
            end_req_reg <= 1'b0;
          end
        ST_RST_PULSE:
          if (timer_reg == '0)
          begin
            state_reg <= ST_PWR_WAIT;
            timer_reg <= 32'(POWER_UP_WAIT - 1);
            tgt_rst_n_o <= 1'b0;
          end
          else
          begin
            timer_reg <= timer_reg - 32'h1;
            tgt_rst_n_o <= 1'b1;
          end
        ST_PWR_WAIT:
          if (timer_reg == '0)
          begin
            state_reg <= ST_SHIFT;
            enabling_reg <= 1'b1;
          end
          else
            timer_reg <= timer_reg - 32'h1;
        ST_SHIFT:
          if (xfer_done && enabling_reg && !echo_ok)
          begin
            // Pulse starts a cycle late so SCK is already low
            state_reg <= ST_RST_PULSE;
            timer_reg <= 32'(RST_PULSE_CYC);
          end
          else if (xfer_done && enabling_reg)
          begin
            state_reg <= ST_READY;
            enabling_reg <= 1'b0;
          end
          else if (xfer_done)
          begin
            state_reg <= ST_WAIT;
            timer_reg <= wait_of(op_reg, sel_reg);
          end
        ST_WAIT:
          if (timer_reg <= 32'h1)
            state_reg <= ST_READY;
          else
            timer_reg <= timer_reg - 32'h1;
        ST_READY:
          if (end_req_reg || end_i)
          begin
            state_reg <= ST_IDLE;
            tgt_rst_n_o <= 1'b1;
            end_req_reg <= 1'b0;
          end
          else if (take)
            state_reg <= ST_SHIFT;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Bit shifter
  // --------------------------------------------------------------------------
  // MISO is read just before the rise, a full phase after the target moved it
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_reg <= '0;
      rx_reg <= '0;
      op_reg <= '0;
      sel_reg <= '0;
      ph_cnt_reg <= '0;
      bit_cnt_reg <= '0;
      sck_o <= 1'b0;
    end
    else if (state_reg == ST_PWR_WAIT && timer_reg == '0)
    begin
      tx_reg <= {OP_PROG_ENABLE, ENABLE_ECHO, 16'h0000};
      op_reg <= OP_PROG_ENABLE;
      sel_reg <= ENABLE_ECHO;
      ph_cnt_reg <= '0;
      bit_cnt_reg <= '0;
    end
    else if (take)
    begin
      op_reg <= f_data.op;
      sel_reg <= f_data.addr_hi;
      ph_cnt_reg <= '0;
      bit_cnt_reg <= '0;
      if (is_load(f_data.op))
        tx_reg <= {f_data.op, f_data.addr_hi, f_data.addr_lo & LOAD_ADDR_MASK, f_data.data};
      else
        tx_reg <= f_data;
    end
    else if (state_reg == ST_SHIFT)
    begin
      ph_cnt_reg <= ph_done ? '0 : ph_cnt_reg + 16'h1;
      if (ph_done && !sck_o)
      begin
        sck_o <= 1'b1;
        rx_reg <= {rx_reg[30:0], miso_sync_reg[1]};
      end
      else if (ph_done)
      begin
        sck_o <= 1'b0;
        tx_reg <= {tx_reg[30:0], 1'b0};
        bit_cnt_reg <= bit_cnt_reg + 5'h1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Status and answers
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rsp_valid_o <= 1'b0;
      rsp_o <= '0;
      active_o <= 1'b0;
      enabled_o <= 1'b0;
      sync_fail_o <= 1'b0;
      order_err_o <= 1'b0;
      lo_addr_reg <= '0;
      lo_valid_reg <= 1'b0;
    end
    else
    begin
      rsp_valid_o <= xfer_done && !enabling_reg;
      if (xfer_done && !enabling_reg)
        rsp_o <= '{op: op_reg, data: rx_reg[7:0]};
      sync_fail_o <= xfer_done && enabling_reg && !echo_ok;
      active_o <= state_reg != ST_IDLE || start_i;
      if (xfer_done && enabling_reg && echo_ok)
        enabled_o <= 1'b1;
      else if (state_reg == ST_IDLE || state_reg == ST_RST_PULSE)
        enabled_o <= 1'b0;
      if (state_reg == ST_IDLE && start_i)
      begin
        order_err_o <= 1'b0;
        lo_valid_reg <= 1'b0;
      end
      else if (take && is_load(f_data.op))
      begin
        if (!f_data.op[LOAD_HIGH_BIT])
        begin
          lo_addr_reg <= f_data.addr_lo & LOAD_ADDR_MASK;
          lo_valid_reg <= 1'b1;
        end
        else
        begin
          lo_valid_reg <= 1'b0;
          if (!lo_valid_reg || lo_addr_reg != (f_data.addr_lo & LOAD_ADDR_MASK))
            order_err_o <= 1'b1;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  logic [31:0] sck_hi_len;
  logic [31:0] sck_lo_len;
  logic [31:0] rst_hi_len;
  logic [31:0] rst_lo_len;
  logic [5:0] rise_cnt;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sck_hi_len <= '0;
      sck_lo_len <= '0;
      rst_hi_len <= '0;
      rst_lo_len <= '0;
      rise_cnt <= '0;
    end
    else
    begin
      sck_hi_len <= sck_o ? sck_hi_len + 32'h1 : '0;
      sck_lo_len <= sck_o ? '0 : sck_lo_len + 32'h1;
      rst_hi_len <= tgt_rst_n_o ? rst_hi_len + 32'h1 : '0;
      rst_lo_len <= tgt_rst_n_o ? '0 : rst_lo_len + 32'h1;
      if (take || (state_reg == ST_PWR_WAIT))
        rise_cnt <= '0;
      else if (state_reg == ST_SHIFT && ph_done && !sck_o)
        rise_cnt <= rise_cnt + 6'h1;
    end
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_bad_echo;
    xfer_done && enabling_reg && !echo_ok;
  endsequence
  sequence s_page_write_done;
    xfer_done && !enabling_reg && op_reg == OP_WRITE_PAGE;
  endsequence

  sck_in_reset_a: assert property (sck_o |-> !tgt_rst_n_o)
    else $error("SCK high while target reset released");
  sck_high_len_a: assert property ($fell(sck_o) |-> sck_hi_len == SCK_PHASE_CYC)
    else $error("SCK high phase has wrong length");
  sck_low_len_a: assert property ($rose(sck_o) |-> sck_lo_len >= SCK_PHASE_CYC)
    else $error("SCK low phase too short");
  rst_pulse_len_a: assert property ($fell(tgt_rst_n_o) |-> rst_hi_len >= RST_PULSE_CYC)
    else $error("Target reset pulse too short");
  pulse_sck_low_a: assert property ($rose(tgt_rst_n_o) |-> !sck_o)
    else $error("Reset pulse given with SCK high");
  power_wait_a: assert property ($rose(sck_o) |-> rst_lo_len >= POWER_UP_WAIT)
    else $error("SCK started before power-up wait");
  mosi_stable_a: assert property (sck_o |-> $stable(mosi_o))
    else $error("MOSI changed while SCK high");
  echo_check_a: assert property ($rose(enabled_o) |-> $past(rx_reg[15:8]) == ENABLE_ECHO)
    else $error("Enabled without a correct echo");
  four_bytes_a: assert property (xfer_done |-> rise_cnt == 6'd32)
    else $error("Instruction did not carry 32 bits");
  retry_pulse_a: assert property (s_bad_echo |=> !tgt_rst_n_o ##1 $rose(tgt_rst_n_o) ##1 tgt_rst_n_o)
    else $error("Bad echo not followed by reset pulse");
  page_quiet_a: assert property (s_page_write_done |=> (state_reg == ST_WAIT && !sck_o)[*8])
    else $error("Link touched during page write");
  eeprom_wait_a: assert property (xfer_done && !enabling_reg && op_reg == OP_WRITE_EEPROM
    |=> state_reg == ST_WAIT && timer_reg == EEPROM_WAIT)
    else $error("EEPROM wait not loaded");
  load_mask_a: assert property (take && is_load(f_data.op) |=> tx_reg[15:13] == 3'h0)
    else $error("Page load address not masked");
  end_release_a: assert property ($rose(tgt_rst_n_o) |-> state_reg inside {ST_IDLE, ST_RST_PULSE})
    else $error("Target reset released outside session end or pulse");

endmodule : smpp_host

// ---- smpp_tgt_model.sv ----
// Behavioural target device on the serial programming link
module smpp_tgt_model #(
  parameter int unsigned CPU_PERIOD_NS = 128,
  parameter int unsigned PWR_WAIT_NS = 20000000,
  parameter int unsigned WRITE_BUSY_NS = 4000000,
  parameter int unsigned ERASE_BUSY_NS = 8000000
) (
  input wire logic tgt_rst_n_i,
  input wire logic tgt_clk_i,
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic desync_i,
  output logic miso_o,
  output logic viol_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------------------------------------
  // Memories and link state
  // --------------------------------------------------------------------------
  logic [7:0] flash[int];
  logic [7:0] ee[int];
  logic [7:0] pbuf[int];
  logic [31:0] rx;
  logic [7:0] tx;
  int n = 0;
  bit enabled = 1'b0;
  time t_edge = 0;
  time t_clk = 0;
  time t_rst = 0;
  time busy_until = 0;

  initial
  begin
    miso_o = 1'b0;
    viol_o = 1'b0;
  end

  // --------------------------------------------------------------------------
  // Host-side timing checks
  // --------------------------------------------------------------------------
  always @(tgt_clk_i)
  begin
    t_clk = $time;
    // Released pin: toggles so a stale level is never mistaken for data
    if (tgt_rst_n_i === 1'b1)
      miso_o = (miso_o === 1'b1) ? 1'b0 : 1'b1;
  end

  always @(tgt_rst_n_i)
  begin
    if (tgt_rst_n_i === 1'b0 && t_rst > 0 && $time - t_rst < 2 * CPU_PERIOD_NS)
      viol_o = 1'b1;
    if (sck_i === 1'b1)
      viol_o = 1'b1;
    t_rst = $time;
    n = 0;
    enabled = 1'b0;
  end

  // --------------------------------------------------------------------------
  // Serial shifting
  // --------------------------------------------------------------------------
  function automatic logic [7:0] next_byte();
    logic [7:0] b;
    int k;
    b = rx[7:0];
    k = int'({rx[11:0], rx[19]});
    if (n == 24 && (rx[23:16] & 8'hf7) == 8'h20)
      b = flash.exists(k) ? flash[k] : 8'hff;
    k = int'({rx[8], rx[7:0]});
    if (n == 24 && rx[23:16] == 8'ha0)
      b = ee.exists(k) ? ee[k] : 8'hff;
    if (n == 16 && desync_i === 1'b1)
      b = ~b;
    return b;
  endfunction : next_byte

  task automatic exec();
    int page;
    page = int'({rx[19:16], rx[15:13]});
    // Out of step or still busy: the instruction is lost
    if (desync_i === 1'b1 || $time < busy_until)
      return;
    if (rx[31:24] == 8'hac && rx[23:16] == 8'h53)
      enabled = 1'b1;
    else if (!enabled)
      return;
    else if (rx[31:24] == 8'hac && rx[23:21] == 3'b100)
    begin
      flash.delete();
      ee.delete();
      busy_until = $time + ERASE_BUSY_NS;
    end
    else if ((rx[31:24] & 8'hf7) == 8'h40)
      pbuf[int'({rx[12:8], rx[27]})] = rx[7:0];
    else if (rx[31:24] == 8'h4c)
    begin
      foreach (pbuf[i])
        flash[page * 64 + i] = pbuf[i];
      busy_until = $time + WRITE_BUSY_NS;
    end
    else if (rx[31:24] == 8'hc0)
    begin
      ee[int'({rx[16], rx[15:8]})] = 8'hff;
      ee[int'({rx[16], rx[15:8]})] = rx[7:0];
      busy_until = $time + WRITE_BUSY_NS;
    end
  endtask : exec

  always @(posedge sck_i)
  begin
    if (tgt_rst_n_i !== 1'b0 || $time - t_clk > CPU_PERIOD_NS)
      viol_o = 1'b1;
    if ($time - t_edge <= 2 * CPU_PERIOD_NS)
      viol_o = 1'b1;
    if (!enabled && $time - t_rst < PWR_WAIT_NS)
      viol_o = 1'b1;
    if ($time < busy_until)
      viol_o = 1'b1;
    t_edge = $time;
    rx = {rx[30:0], mosi_i};
    n = n + 1;
    if (n == 32)
    begin
      exec();
      n = 0;
    end
  end

  always @(negedge sck_i)
  begin
    t_edge = $time;
    if (n % 8 == 0)
      tx = next_byte();
    miso_o = tx[7 - n % 8];
  end
endmodule : smpp_tgt_model

// ---- smpp_host_tb_top.sv ----
// Self-checking bench of the serial programming host and its FIFO
module smpp_host_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import smpp_pkg::*;

  // --------------------------------------------------------------------------
  // Signals and bench state
  // --------------------------------------------------------------------------
  localparam int unsigned PWR = 300;
  localparam int unsigned WT = 200;
  logic clk, rst, start, end_s, cmd_valid, cmd_ready_o, rsp_valid_o, active_o, enabled_o;
  logic sync_fail_o, order_err_o, tgt_rst_n_o, tgt_clk_o, sck_o, mosi_o, miso, desync, viol;
  logic [7:0] a_lo, a_hi;
  logic [4:0] w;
  logic [6:0] pg;
  logic [31:0] seed, r;
  smpp_instr_s cmd;
  smpp_rsp_s rsp_o;
  int fails, compares, cyc, nsync;
  logic [7:0] flash_m[int];
  logic [7:0] ee_m[int];
  logic [7:0] buf_m[int];

  smpp_host #(.POWER_UP_WAIT(PWR), .PAGE_WAIT(WT), .EEPROM_WAIT(WT), .ERASE_WAIT(WT),
    .FUSE_WAIT(WT)) smpp_host_inst (.ref_clk_i(clk), .rst_i(rst), .start_i(start),
    .end_i(end_s), .cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_ready_o(cmd_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .active_o(active_o), .enabled_o(enabled_o),
    .sync_fail_o(sync_fail_o), .order_err_o(order_err_o), .tgt_rst_n_o(tgt_rst_n_o),
    .tgt_clk_o(tgt_clk_o), .sck_o(sck_o), .mosi_o(mosi_o), .miso_i(miso));
  // Busy times scaled below the host's shortened waits
  smpp_tgt_model #(.CPU_PERIOD_NS(2 * TGT_CLK_HALF_NS), .PWR_WAIT_NS(PWR * CLK_PERIOD_NS),
    .WRITE_BUSY_NS(1400), .ERASE_BUSY_NS(1500)) smpp_tgt_model_inst (.tgt_rst_n_i(tgt_rst_n_o),
    .tgt_clk_i(tgt_clk_o), .sck_i(sck_o), .mosi_i(mosi_o), .desync_i(desync), .miso_o(miso),
    .viol_o(viol));

  always #4 clk = ~clk;

  // Two enable attempts and nine instructions need about 91000 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 100000)
    begin
      fails++;
      summarize();
    end
  end

  // Link falls back into step once the host has seen a bad echo
  always @(negedge clk)
  begin
    if (sync_fail_o === 1'b1)
    begin
      nsync++;
      desync <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic xfer(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3,
    input logic [7:0] d);
    int k;
    logic [7:0] exp;
    exp = b3;
    k = int'({b2[3:0], b3, op[3]});
    if ((op & 8'hf7) == 8'h20)
      exp = flash_m.exists(k) ? flash_m[k] : 8'hff;
    k = int'({b2[0], b3});
    if (op == 8'ha0)
      exp = ee_m.exists(k) ? ee_m[k] : 8'hff;
    if (op == 8'hc0)
      ee_m[k] = d;
    if ((op & 8'hf7) == 8'h40)
    begin
      exp = b3 & 8'h1f;
      buf_m[int'({b3[4:0], op[3]})] = d;
    end
    if (op == 8'h4c)
      foreach (buf_m[i])
        flash_m[int'({b2[3:0], b3[7:5]}) * 64 + i] = buf_m[i];
    if (op == 8'hac)
    begin
      flash_m.delete();
      ee_m.delete();
    end
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = {op, b2, b3, d};
    while (cmd_ready_o !== 1'b1)
      @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    while (rsp_valid_o !== 1'b1)
      @(negedge clk);
    check(32'(rsp_o.op), 32'(op));
    check(32'(rsp_o.data), 32'(exp));
  endtask : xfer

  task automatic fifo_test();
    int n;
    n = 0;
    @(negedge clk);
    cmd_valid = 1'b1;
    // Idle host never drains, so the queue must fill and refuse
    while (cmd_ready_o === 1'b1 && n < 20)
    begin
      cmd = rnd();
      n++;
      @(negedge clk);
    end
    cmd_valid = 1'b0;
    check(32'(n), 32'(FIFO_DEPTH));
    check(32'(cmd_ready_o), 32'h0);
    // Only a reset empties it again
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check(32'(cmd_ready_o), 32'h1);
  endtask : fifo_test

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    {start, end_s, cmd_valid} = '0;
    cmd = '0;
    desync = 1'b1;
    seed = 32'd20;
    {fails, compares, cyc, nsync} = '0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    fifo_test();
    check(32'({sck_o, tgt_rst_n_o, active_o}), 32'h0);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    @(negedge clk);
    check(32'({tgt_rst_n_o, active_o}), 32'h3);
    for (int i = 0; i < 40000 && enabled_o !== 1'b1; i++)
      @(negedge clk);
    check(32'(nsync), 32'h1);
    check(32'(enabled_o), 32'h1);
    repeat (20) @(negedge clk);
    r = rnd();
    w = r[4:0];
    pg = r[14:8];
    a_lo = r[23:16];
    a_hi = r[31:24];
    xfer(8'h40, 8'h00, {pg[2:0], w}, a_lo);
    xfer(8'h48, 8'h00, {pg[2:0], w}, a_hi);
    xfer(8'h4c, {4'h0, pg[6:3]}, {pg[2:0], 5'h00}, 8'h00);
    xfer(8'h28, {4'h0, pg[6:3]}, {pg[2:0], w}, 8'h00);
    r = rnd();
    xfer(8'hc0, {7'h00, r[8]}, r[7:0], r[23:16]);
    xfer(8'ha0, {7'h00, r[8]}, r[7:0], 8'h00);
    xfer(8'hac, 8'h80, 8'h00, 8'h00);
    xfer(8'ha0, {7'h00, r[8]}, r[7:0], 8'h00);
    xfer(8'h20, {4'h0, pg[6:3]}, {pg[2:0], w}, 8'h00);
    check(32'(order_err_o), 32'h0);
    check(32'(viol), 32'h0);
    end_s = 1'b1;
    @(negedge clk);
    end_s = 1'b0;
    repeat (140) @(negedge clk);
    check(32'({tgt_rst_n_o, active_o, enabled_o}), 32'h4);
    summarize();
  end
endmodule : smpp_host_tb_top
